//--- core/can_retry_pkg.sv
// shared types and constants for the transmit retry and acceptance block
package can_retry_pkg;

    localparam int          NUM_OBJECTS        = 15;
    localparam logic [3:0]  LOWEST_RANK        = 4'hE;   // object fourteen ranks lowest
    localparam logic [2:0]  INTERMISSION_SHORT = 3'h3;   // bits after a frame
    localparam logic [2:0]  INTERMISSION_LONG  = 3'h4;   // bits after lost arbitration when nothing accepted
    localparam logic [2:0]  EOF_STATUS_BIT     = 3'h6;   // status posted after this eof bit
    localparam logic [14:0] ENABLE_RESET       = 15'h0000;
    localparam logic [2:0]  COUNT_RESET        = 3'h0;

    // bus phase seen by the transmit scheduler
    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'b0001,
        ST_FRAME = 4'b0010,
        ST_INTER = 4'b0100,
        ST_TX    = 4'b1000
    } sched_state_t;

    // per-bit strobes from the bit stream engine
    typedef struct packed
    {
        logic bit_tick;      // one bit time elapsed
        logic bus_idle;      // recessive bit sampled outside a frame
        logic frame_start;   // start of frame seen
        logic dlc_first;     // first bit of the dlc field
        logic eof_bit;       // an end of frame bit
        logic frame_good;    // frame received without error
        logic arb_lost;      // arbitration lost in this frame
        logic frame_end;     // last bit of the frame
    } bit_events_t;

    typedef struct packed
    {
        sched_state_t state;
        logic [2:0]   inter_cnt;
        logic [2:0]   inter_need;
        logic [2:0]   eof_cnt;
        logic         pending;
        logic [14:0]  rx_enable;
        logic [14:0]  rx_ok;
        logic [3:0]   winner;
        logic         winner_valid;
        logic         tx_start;
    } retry_state_t;

endpackage : can_retry_pkg

//--- core/can_tx_intermission_retry.sv
// transmit start and retry timing with receive object acceptance
`timescale 1ns/1ps

module can_tx_intermission_retry
    import can_retry_pkg::*;
(
    input  wire logic                     clk_sys_i,
    input  wire logic                     sys_rst_i,
    input  wire can_retry_pkg::bit_events_t ev_i,
    input  wire logic                     tx_request_i,
    input  wire logic [14:0]              rx_enable_set_i,
    input  wire logic [14:0]              filter_match_i,
    output logic                          tx_start_o,
    output logic [14:0]                   rx_enable_o,
    output logic [14:0]                   receive_ok_flag_o,
    output logic [3:0]                    accept_object_o,
    output logic                          accept_valid_o
);
    import can_retry_pkg::*;

    retry_state_t s_reg;
    retry_state_t s_next;
    logic [14:0]  candidates;
    logic [3:0]   pick;
    logic         pick_valid;
    logic [2:0]   eof_next;
    logic         post_now;
    logic [14:0]  post_mask;

    // rank search: lower number wins, fourteen only when alone
    always_comb
    begin
        candidates = s_reg.rx_enable & filter_match_i;
        pick       = LOWEST_RANK;
        pick_valid = 1'b0;
        for (int i = NUM_OBJECTS - 1; i >= 0; i--)
        begin
            if (candidates[i])
            begin
                pick       = 4'(i);
                pick_valid = 1'b1;
            end
        end
    end

    // status post strobe: sixth eof bit of a good frame that an object took
    assign eof_next = s_reg.eof_cnt + 3'h1;
    assign post_now = ev_i.bit_tick && ev_i.eof_bit && ev_i.frame_good
                      && s_reg.winner_valid && (eof_next == EOF_STATUS_BIT);

    // one-hot mask of the object whose status is posted this cycle
    always_comb
    begin
        post_mask = 15'h0000;
        if (post_now)
        begin
            post_mask[s_reg.winner] = 1'b1;
        end
    end

    // next state of scheduler, acceptance and status
    always_comb
    begin
        s_next          = s_reg;
        s_next.tx_start = 1'b0;
        // enables taken at any time except for the object posting that cycle; only enables held at dlc count
        s_next.rx_enable = s_reg.rx_enable | rx_enable_set_i;
        if (tx_request_i)
        begin
            s_next.pending = 1'b1;
        end
        // acceptance decided at first dlc bit, so late enables miss it
        if (ev_i.bit_tick && ev_i.dlc_first)
        begin
            s_next.winner       = pick;
            s_next.winner_valid = pick_valid;
        end
        // eof counting toward the status post
        if (ev_i.bit_tick && ev_i.eof_bit)
        begin
            s_next.eof_cnt = eof_next;
            if (post_now)
            begin
                s_next.rx_ok     = s_next.rx_ok | post_mask;
                s_next.rx_enable = s_next.rx_enable & ~post_mask;
            end
        end
        // software re-enable clears the ok flag, unless set wins this cycle
        for (int j = 0; j < NUM_OBJECTS; j++)
        begin
            if (rx_enable_set_i[j] && !(s_next.rx_ok[j] && !s_reg.rx_ok[j]))
            begin
                s_next.rx_ok[j] = 1'b0;
            end
        end
        case (s_reg.state)
            // quiet bus: a frame starts, or a pending start goes on an idle bit
            ST_IDLE:
            begin
                if (ev_i.frame_start)
                begin
                    s_next.state   = ST_FRAME;
                    s_next.eof_cnt = COUNT_RESET;
                end
                else if (s_reg.pending && ev_i.bit_tick && ev_i.bus_idle)
                begin
                    s_next.state    = ST_TX;
                    s_next.tx_start = 1'b1;
                    s_next.pending  = 1'b0;
                end
            end
            // frame on the bus: the gap to wait is chosen at its last bit
            ST_FRAME:
            begin
                if (ev_i.frame_start)
                begin
                    // a cut frame followed by a new start: restart eof counting
                    s_next.eof_cnt      = COUNT_RESET;
                    s_next.winner_valid = 1'b0;
                end
                else if (ev_i.frame_end)
                begin
                    s_next.state     = ST_INTER;
                    s_next.inter_cnt = COUNT_RESET;
                    s_next.inter_need = INTERMISSION_SHORT;
                    if (ev_i.arb_lost)
                    begin
                        s_next.pending = 1'b1;
                        if (!s_reg.winner_valid)
                        begin
                            s_next.inter_need = INTERMISSION_LONG;
                        end
                        else
                        begin
                            s_next.inter_need = INTERMISSION_SHORT;
                        end
                    end
                    // accept result stands only until the frame's last bit
                    s_next.winner_valid = 1'b0;
                end
            end
            // intermission: count bit times, a new frame start cuts the wait
            ST_INTER:
            begin
                if (ev_i.frame_start)
                begin
                    // another node started first; we retry after it
                    s_next.state   = ST_FRAME;
                    s_next.eof_cnt = COUNT_RESET;
                end
                else if (ev_i.bit_tick)
                begin
                    s_next.inter_cnt = s_reg.inter_cnt + 3'h1;
                    if (s_reg.inter_cnt + 3'h1 >= s_reg.inter_need)
                    begin
                        if (s_reg.pending)
                        begin
                            s_next.state    = ST_TX;
                            s_next.tx_start = 1'b1;
                            s_next.pending  = 1'b0;
                        end
                        else
                        begin
                            s_next.state = ST_IDLE;
                        end
                    end
                end
            end
            ST_TX:
            begin
                // own frame now on the bus; tracked as a frame
                s_next.state   = ST_FRAME;
                s_next.eof_cnt = COUNT_RESET;
            end
            default:
            begin
                s_next.state = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            // no object enabled and nothing pending out of reset
            s_reg.state        <= ST_IDLE;
            s_reg.inter_cnt    <= COUNT_RESET;
            s_reg.inter_need   <= INTERMISSION_SHORT;
            s_reg.eof_cnt      <= COUNT_RESET;
            s_reg.pending      <= 1'b0;
            s_reg.rx_enable    <= ENABLE_RESET;
            s_reg.rx_ok        <= ENABLE_RESET;
            s_reg.winner       <= LOWEST_RANK;
            s_reg.winner_valid <= 1'b0;
            s_reg.tx_start     <= 1'b0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state flops, so they never glitch
    assign tx_start_o        = s_reg.tx_start;
    assign rx_enable_o       = s_reg.rx_enable;
    assign receive_ok_flag_o = s_reg.rx_ok;
    assign accept_object_o   = s_reg.winner;
    assign accept_valid_o    = s_reg.winner_valid;

endmodule : can_tx_intermission_retry

//--- bench/retry_monitor.sv
// checker for retry timing, status posting and object ranking
`timescale 1ns/1ps
module retry_monitor
    import can_retry_pkg::*;
(
    input wire logic                       clk_sys_i,
    input wire logic                       sys_rst_i,
    input wire can_retry_pkg::bit_events_t ev_i,
    input wire logic                       tx_request_i,
    input wire logic [14:0]                rx_enable_set_i,
    input wire logic [14:0]                filter_match_i,
    input wire logic                       tx_start_o,
    input wire logic [14:0]                rx_enable_o,
    input wire logic [14:0]                receive_ok_flag_o,
    input wire logic [3:0]                 accept_object_o,
    input wire logic                       accept_valid_o
);
    logic [2:0] eof_n;
    logic [3:0] low;
    wire tk = ev_i.bit_tick;
    wire eof6 = ev_i.eof_bit && tk && eof_n == 3'h5;
    wire lost = ev_i.frame_end && ev_i.arb_lost;
    wire hit = |(rx_enable_o & filter_match_i);
    wire [14:0] en_or = rx_enable_o | rx_enable_set_i;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // eof bits counted per frame, restarted at start of frame
    always_ff @(posedge clk_sys_i)
        if (sys_rst_i || ev_i.frame_start)
            eof_n <= 3'h0;
        else if (ev_i.eof_bit && tk)
            eof_n <= eof_n + 3'h1;
    // own ranking, so a wrong priority in the design shows up
    always_comb
    begin
        low = LOWEST_RANK;
        for (int i = 14; i >= 0; i--)
            if (rx_enable_o[i] && filter_match_i[i])
                low = 4'(i);
    end
    property p_wait3; ev_i.frame_end |=> !tx_start_o [*3]; endproperty
    a_wait3: assert property (p_wait3) else $error("start too soon");
    property p_retry3; lost && accept_valid_o ##1 (tk && !ev_i.frame_start) [*3]
        |=> tx_start_o; endproperty
    a_retry3: assert property (p_retry3) else $error("no retry after 3");
    property p_wait4; lost && !accept_valid_o |=> !tx_start_o [*4]; endproperty
    a_wait4: assert property (p_wait4) else $error("retry before 4");
    property p_post; eof6 && ev_i.frame_good && accept_valid_o |=>
        receive_ok_flag_o[$past(accept_object_o)] && !rx_enable_o[$past(accept_object_o)];
    endproperty
    a_post: assert property (p_post) else $error("status not posted");
    property p_rank; ev_i.dlc_first && tk |=> accept_valid_o == $past(hit)
        && (!accept_valid_o || accept_object_o == $past(low)); endproperty
    a_rank: assert property (p_rank) else $error("wrong object");
    property p_off; 1 |=> (rx_enable_o & ~$past(en_or)) == 15'h0; endproperty
    a_off: assert property (p_off) else $error("enable without set");
    c_four: cover property (lost && !accept_valid_o);
    c_three: cover property (lost && accept_valid_o);
    c_post: cover property (eof6 && accept_valid_o);
endmodule : retry_monitor
bind can_tx_intermission_retry retry_monitor u_mon (.clk_sys_i, .sys_rst_i, .ev_i, .tx_request_i,
    .rx_enable_set_i, .filter_match_i, .tx_start_o, .rx_enable_o, .receive_ok_flag_o,
    .accept_object_o, .accept_valid_o);

//--- bench/bus_node_model.sv
// other node on the bus: one frame per go pulse, idle bits otherwise
`timescale 1ns/1ps
module bus_node_model
    import can_retry_pkg::*;
(
    input  wire logic                  clk_sys_i,
    input  wire logic                  go_i,
    input  wire logic                  lost_i,
    output can_retry_pkg::bit_events_t ev_o
);
    int s = 16;
    // one bit a cycle; idle bits keep ticking, the bus is recessive
    always @(negedge clk_sys_i)
    begin
        bit_events_t e;
        e = '0;
        if (go_i)
            s = 0;
        e.bit_tick = 1'b1;
        e.frame_start = (s == 0);
        e.dlc_first = (s == 4);
        e.eof_bit = (s >= 9 && s < 16);
        e.frame_good = (s >= 9 && s < 16);
        e.frame_end = (s == 15);
        e.arb_lost = (s == 15) && lost_i;
        e.bus_idle = (s >= 16);
        ev_o <= e;
        if (s < 16)
            s++;
    end
endmodule : bus_node_model

//--- bench/tb.sv
// bench: acceptance setups and retry gaps against a bench model
`timescale 1ns/1ps
module tb;
    import can_retry_pkg::*;
    logic        clk_sys_i = 0, sys_rst_i = 1, go = 0, lost = 0, tx_request_i = 0;
    logic [14:0] rx_enable_set_i = 0, filter_match_i = 0, rx_enable_o, receive_ok_flag_o;
    logic [14:0] en_m = 0, ok_m = 0, hit;
    logic [3:0]  accept_object_o, w;
    logic        tx_start_o, accept_valid_o;
    bit_events_t ev;
    int          n_fail = 0, checked = 0, cyc = 0, n, k;
    always #5 clk_sys_i = ~clk_sys_i;
    bus_node_model u_node (.clk_sys_i, .go_i(go), .lost_i(lost), .ev_o(ev));
    can_tx_intermission_retry u_dut (.clk_sys_i, .sys_rst_i, .ev_i(ev), .tx_request_i,
        .rx_enable_set_i, .filter_match_i, .tx_start_o, .rx_enable_o, .receive_ok_flag_o,
        .accept_object_o, .accept_valid_o);
    task automatic check(string nm, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // one foreign frame; objects enabled before it starts
    task automatic frame(logic [14:0] en, logic [14:0] m, logic ls, logic rq);
        @(negedge clk_sys_i);
        rx_enable_set_i = en;
        filter_match_i = m;
        lost = ls;
        go <= 1'b1;
        @(negedge clk_sys_i);
        rx_enable_set_i = 0;
        go <= 1'b0;
        en_m |= en;
        ok_m &= ~en;
        @(negedge clk_sys_i);
        tx_request_i = rq;
        @(negedge clk_sys_i);
        tx_request_i = 0;
        hit = en_m & m;
        w = LOWEST_RANK;
        for (int i = 14; i >= 0; i--)
            if (hit[i])
                w = 4'(i);
        // stop at the sixth eof bit: status posted, accept result still stands
        k = 0;
        for (n = 0; n < 30 && k < 6; n++)
        begin
            @(negedge clk_sys_i);
            if (ev.eof_bit === 1'b1)
                k++;
        end
        check("valid", hit != 0, accept_valid_o);
        if (hit != 0)
        begin
            check("object", w, accept_object_o);
            en_m[w] = 0;
            ok_m[w] = 1;
        end
        check("rx_ok", ok_m, receive_ok_flag_o);
        check("enable", en_m, rx_enable_o);
        // negedges after the sixth eof bit until our start; none without a request
        for (n = 0; n < 9; n++)
        begin
            @(negedge clk_sys_i);
            if (tx_start_o === 1'b1)
                break;
        end
        check("gap", !rq ? 9 : (ls && hit == 0) ? 4 : 3, n);
    endtask : frame
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_fail++;
            report_and_stop();
        end
    end
    initial
    begin
        void'($urandom(70));
        repeat (8) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        sys_rst_i = 0;
        check("reset_obj", LOWEST_RANK, accept_object_o);
        frame(15'h0000, 15'h7FFF, 1, 1'h1);
        frame(15'h4000, 15'h4000, 1, 1'h1);
        frame(15'h0000, 15'h4000, 0, 1'h1);
        frame(15'h0000, 15'h0000, 0, 1'h0);
        // request on a quiet bus starts on the next idle bit
        @(negedge clk_sys_i);
        tx_request_i = 1;
        @(negedge clk_sys_i);
        tx_request_i = 0;
        @(negedge clk_sys_i);
        check("idle_start", 1, tx_start_o);
        repeat (10) frame(15'($urandom), 15'($urandom), 1'($urandom), 1'h1);
        report_and_stop();
    end
endmodule : tb
